// *** src/msc_map.svh ***
// Register offsets, bit positions, reset values and timing counts
`ifndef MSC_MAP_SVH
`define MSC_MAP_SVH
`define MSC_OFF_MISC      8'h0c
`define MSC_OFF_IRQ_STAT  8'h10
`define MSC_OFF_IRQ_MASK  8'h11
`define MSC_BIT_POR       7
`define MSC_BIT_RISE      6
`define MSC_BIT_FALL      5
`define MSC_BIT_EXTEN     4
`define MSC_BIT_PULSE_A   3
`define MSC_BIT_PULSE_B   2
`define MSC_BIT_SLOW_BUS  1
`define MSC_BIT_WATCHDOG_ENABLE_BIT      0
`define MSC_PERIOD_SLOW   13'h1000
`define MSC_PERIOD_FAST   13'h0100
`define MSC_DIV_SLOW      6'h20
`define MSC_DIV_FAST      6'h02
`define MSC_EV_EXT        0
`define MSC_EV_WOR        1
`define MSC_EV_WATCHDOG_ENABLE_BIT       2
`define MSC_EV_POR        3
`define MSC_ZERO8         8'h00
`endif

// *** src/msc_pkg.sv ***
// Types shared by the miscellaneous control block
package msc_pkg;
  typedef logic [7:0] msc_byte_t;
  typedef enum logic [1:0] {
    MSC_SENS_FALL_LOW = 2'b00,
    MSC_SENS_FALL     = 2'b01,
    MSC_SENS_RISE     = 2'b10,
    MSC_SENS_BOTH     = 2'b11
  } msc_sens_t;
endpackage

// *** src/msc_edge_det.sv ***
// Edge and level interrupt detector for one input line
`include "msc_map.svh"
module msc_edge_det (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // Control
  input  wire logic          invert,
  input  wire msc_pkg::msc_sens_t sens,
  input  wire logic          enable,
  // Line and request
  input  wire logic          line,
  output logic               req
);
  import msc_pkg::*;
  // ==========================================================
  // Edge detection
  logic prev_q;
  logic lvl;
  logic rise_w;
  logic fall_w;
  logic hit_w;
  // Invert so WOR sensitivity reuses the IRQ table mirrored
  assign lvl    = line ^ invert;
  assign rise_w = lvl & ~prev_q;
  assign fall_w = ~lvl & prev_q;
  assign hit_w  = (sens == MSC_SENS_FALL_LOW) ? (fall_w | ~lvl) :
                  (sens == MSC_SENS_FALL)     ? fall_w :
                  (sens == MSC_SENS_RISE)     ? rise_w :
                                                (rise_w | fall_w);
  // Previous line value and request register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_q <= 1'b1;  // Idle level of either line after inversion
      req    <= 1'b0;
    end else begin
      prev_q <= lvl;
      req    <= enable & hit_w;
    end
  end
endmodule

// *** src/msc_top.sv ***
// Miscellaneous system control register with interrupt sensitivity
//
// Overview of operation
// - Power-on sets flag; software only clears it
// - Select bits writable with CPU mask; reset clears
// - IRQ pin sensitivity follows two select bits
// - Wired-OR sensitivity follows the mirrored table
// - Enable gates external interrupt; reset sets it
// - Modulator A period slow 4096, fast 256
// - Modulator B period slow 4096, fast 256
// - Slow bus divides oscillator by 32, else 2
// - Slow bus cleared by reset and stop
// - Writing one clears and enables watchdog
// - Watchdog enable takes option after any reset
// - Wired-OR enable raises request from inputs
//
// The address-and-strobe port was left to the implementer.
`include "msc_map.svh"
module msc_top #(
  parameter int  PORT_W    = 8,
  parameter bit  WATCHDOG_ENABLE_BIT_OPT  = 1'b0
) (
  // Clock and resets
  input  wire logic               CLK,
  input  wire logic               NRST,
  input  wire logic               POR_EVENT,
  input  wire logic               EXT_RESET,
  input  wire logic               WATCHDOG_ENABLE_BIT_RESET,
  // Register port
  input  wire logic [7:0]         ADDR,
  input  wire logic [7:0]         WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  output msc_pkg::msc_byte_t      RDATA,
  // CPU state
  input  wire logic               CPU_IMASK,
  input  wire logic               STOP_ENTRY,
  // Interrupt sources
  input  wire logic               IRQ_N,
  input  wire logic [PORT_W-1:0]  PORTB_IN,
  input  wire logic [PORT_W-1:0]  PORTB_DDR,
  input  wire logic               WIRED_OR_INT_ENABLE,
  // Outputs
  output logic                    EXT_IRQ_REQ,
  output logic                    IRQ_OUT,
  output logic [12:0]             PULSE_A_PERIOD,
  output logic [12:0]             PULSE_B_PERIOD,
  output logic [5:0]              BUS_DIVIDE,
  output logic                    SLOW_BUS_SELECT,
  output logic                    WATCHDOG_ENABLE,
  output logic                    WATCHDOG_CLEAR
);
  import msc_pkg::*;
  // ==========================================================
  // Register state
  logic       por_q;
  logic       rise_q;
  logic       fall_q;
  logic       exten_q;
  logic       pulse_a_slow_q;
  logic       pulse_b_slow_q;
  logic       slow_bus_q;
  logic       watchdog_enable_bit_q;
  logic [3:0] stat_q;
  logic [3:0] mask_q;
  logic       boot_q;
  logic       ext_rst_d1_q;
  msc_sens_t  sens_w;
  // ==========================================================
  // Decode
  logic       wr_misc;
  logic       wr_stat;
  logic       wr_mask;
  logic       wr_prot;
  logic       hard_rst;
  logic [7:0] misc_rd;
  logic [7:0] rd_mux;
  assign wr_misc  = WR & (ADDR == `MSC_OFF_MISC);
  assign wr_stat  = WR & (ADDR == `MSC_OFF_IRQ_STAT);
  assign wr_mask  = WR & (ADDR == `MSC_OFF_IRQ_MASK);
  assign wr_prot  = wr_misc & CPU_IMASK;
  assign hard_rst = POR_EVENT | EXT_RESET;
  assign sens_w   = msc_sens_t'({rise_q, fall_q});
  // Read image with flag on top and watchdog at bottom
  assign misc_rd  = {por_q, rise_q, fall_q, exten_q,
                     pulse_a_slow_q, pulse_b_slow_q,
                     slow_bus_q, watchdog_enable_bit_q};
  assign rd_mux   = (ADDR == `MSC_OFF_MISC)     ? misc_rd :
                    (ADDR == `MSC_OFF_IRQ_STAT) ? {4'h0, stat_q} :
                    (ADDR == `MSC_OFF_IRQ_MASK) ? {4'h0, mask_q} :
                                                  `MSC_ZERO8;
  // ==========================================================
  // Interrupt detectors
  logic              irq_hit;
  logic [PORT_W-1:0] wor_hit;
  logic              wor_any;
  msc_edge_det u_irq (
    .clk    (CLK),
    .nrst   (NRST),
    .invert (1'b0),
    .sens   (sens_w),
    .enable (exten_q),
    .line   (IRQ_N),
    .req    (irq_hit)
  );
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_wor
      // Inverted line mirrors the table for wired-OR pins
      msc_edge_det u_wor (
        .clk    (CLK),
        .nrst   (NRST),
        .invert (1'b1),
        .sens   (sens_w),
        .enable (WIRED_OR_INT_ENABLE & ~PORTB_DDR[gi]),
        .line   (PORTB_IN[gi]),
        .req    (wor_hit[gi])
      );
    end
  endgenerate
  assign wor_any = |wor_hit;
  // ==========================================================
  // Power-on flag
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      por_q <= 1'b0;
    end else if (POR_EVENT) begin
      por_q <= 1'b1;
    end else if (wr_misc && !WDATA[`MSC_BIT_POR]) begin
      por_q <= 1'b0;
    end
  end
  // Sensitivity and enable, writable only with CPU mask set
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
      exten_q <= 1'b1;
    end else if (hard_rst) begin
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
      exten_q <= 1'b1;
    end else if (wr_prot) begin
      rise_q  <= WDATA[`MSC_BIT_RISE];
      fall_q  <= WDATA[`MSC_BIT_FALL];
      exten_q <= WDATA[`MSC_BIT_EXTEN];
    end
  end
  // Modulator speed bits, applied at once without buffering
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pulse_a_slow_q <= 1'b0;
      pulse_b_slow_q <= 1'b0;
    end else if (hard_rst) begin
      pulse_a_slow_q <= 1'b0;
      pulse_b_slow_q <= 1'b0;
    end else if (wr_misc) begin
      pulse_a_slow_q <= WDATA[`MSC_BIT_PULSE_A];
      pulse_b_slow_q <= WDATA[`MSC_BIT_PULSE_B];
    end
  end
  // Slow bus bit
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      slow_bus_q <= 1'b0;
    end else if (hard_rst || STOP_ENTRY) begin
      slow_bus_q <= 1'b0;
    end else if (wr_misc) begin
      slow_bus_q <= WDATA[`MSC_BIT_SLOW_BUS];
    end
  end
  // Watchdog enable: option value after reset, software sets only
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      watchdog_enable_bit_q         <= 1'b0;
      boot_q         <= 1'b1;
      WATCHDOG_CLEAR <= 1'b0;
    end else begin
      boot_q         <= 1'b0;
      WATCHDOG_CLEAR <= wr_misc & WDATA[`MSC_BIT_WATCHDOG_ENABLE_BIT];
      if (boot_q || hard_rst || WATCHDOG_ENABLE_BIT_RESET) begin
        watchdog_enable_bit_q <= WATCHDOG_ENABLE_BIT_OPT;
      end else if (wr_misc && WDATA[`MSC_BIT_WATCHDOG_ENABLE_BIT]) begin
        watchdog_enable_bit_q <= 1'b1;
      end
    end
  end
  // ==========================================================
  // Sticky event status; set wins over clear
  logic [3:0] ev_w;
  assign ev_w[`MSC_EV_EXT]  = irq_hit;
  assign ev_w[`MSC_EV_WOR]  = wor_any;
  assign ev_w[`MSC_EV_WATCHDOG_ENABLE_BIT] = WATCHDOG_ENABLE_BIT_RESET;
  assign ev_w[`MSC_EV_POR]  = POR_EVENT;
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      stat_q <= 4'h0;
      mask_q <= 4'h0;
    end else begin
      stat_q <= (stat_q & ~(wr_stat ? WDATA[3:0] : 4'h0)) | ev_w;
      if (wr_mask) begin
        mask_q <= WDATA[3:0];
      end
    end
  end
  // ==========================================================
  // Registered outputs
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      RDATA           <= `MSC_ZERO8;
      EXT_IRQ_REQ     <= 1'b0;
      IRQ_OUT         <= 1'b0;
      PULSE_A_PERIOD  <= `MSC_PERIOD_FAST;
      PULSE_B_PERIOD  <= `MSC_PERIOD_FAST;
      BUS_DIVIDE      <= `MSC_DIV_FAST;
      SLOW_BUS_SELECT <= 1'b0;
      WATCHDOG_ENABLE <= 1'b0;
    end else begin
      RDATA           <= RD ? rd_mux : `MSC_ZERO8;
      EXT_IRQ_REQ     <= irq_hit | wor_any;
      IRQ_OUT         <= |(stat_q & mask_q);
      PULSE_A_PERIOD  <= pulse_a_slow_q ? `MSC_PERIOD_SLOW
                                        : `MSC_PERIOD_FAST;
      PULSE_B_PERIOD  <= pulse_b_slow_q ? `MSC_PERIOD_SLOW
                                        : `MSC_PERIOD_FAST;
      BUS_DIVIDE      <= slow_bus_q ? `MSC_DIV_SLOW
                                    : `MSC_DIV_FAST;
      SLOW_BUS_SELECT <= slow_bus_q;
      WATCHDOG_ENABLE <= watchdog_enable_bit_q;
    end
  end
  // ==========================================================
  // Checks
  chk_por_set: assert property (@(posedge CLK) disable iff (!NRST)
    POR_EVENT |=> por_q)
    else $error("power-on flag not set");
  chk_por_nosw: assert property (@(posedge CLK) disable iff (!NRST)
    (!por_q && !POR_EVENT) |=> !por_q)
    else $error("power-on flag set by software");
  chk_sel_guard: assert property (@(posedge CLK) disable iff (!NRST)
    (!CPU_IMASK && !hard_rst) |=> $stable({rise_q, fall_q, exten_q}))
    else $error("select bits changed with mask clear");
  chk_ext_reset: assert property (@(posedge CLK) disable iff (!NRST)
    hard_rst |=> (!rise_q && !fall_q && exten_q))
    else $error("reset values of select bits wrong");
  chk_pwm_a: assert property (@(posedge CLK) disable iff (!NRST)
    pulse_a_slow_q |=> PULSE_A_PERIOD == `MSC_PERIOD_SLOW)
    else $error("modulator A period wrong");
  chk_pwm_b: assert property (@(posedge CLK) disable iff (!NRST)
    !pulse_b_slow_q |=> PULSE_B_PERIOD == `MSC_PERIOD_FAST)
    else $error("modulator B period wrong");
  chk_bus_div: assert property (@(posedge CLK) disable iff (!NRST)
    slow_bus_q |=> BUS_DIVIDE == `MSC_DIV_SLOW)
    else $error("slow bus divide wrong");
  chk_stop_clr: assert property (@(posedge CLK) disable iff (!NRST)
    STOP_ENTRY |=> ##1 !SLOW_BUS_SELECT)
    else $error("slow bus not cleared at stop");
  chk_watchdog_enable_bit_keep: assert property (@(posedge CLK) disable iff (!NRST)
    (watchdog_enable_bit_q && !boot_q && !hard_rst && !WATCHDOG_ENABLE_BIT_RESET) |=> watchdog_enable_bit_q)
    else $error("watchdog disabled by software");
  chk_watchdog_enable_bit_opt: assert property (@(posedge CLK) disable iff (!NRST)
    WATCHDOG_ENABLE_BIT_RESET |=> watchdog_enable_bit_q == WATCHDOG_ENABLE_BIT_OPT)
    else $error("watchdog option value not taken");
  cov_por: cover property (@(posedge CLK) POR_EVENT ##1 wr_misc);
  cov_irq: cover property (@(posedge CLK) irq_hit ##2 IRQ_OUT);
  cov_wor: cover property (@(posedge CLK) wor_any);
  cov_watchdog_enable_bit: cover property (@(posedge CLK) WATCHDOG_CLEAR);
endmodule

// *** dv/misc_system_control_register_tb.sv ***
// Self-checking testbench for the miscellaneous control register block
module misc_system_control_register_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Stimulus and observed signals
  logic               clk, nrst, por_ev, ext_rst, wd_rst, wr, rd;
  logic               imask, stop, irq_n, wor_en;
  logic [7:0]         addr, wdata, pb_in, pb_ddr;
  msc_pkg::msc_byte_t rdata;
  logic               ext_req, irq_out, sbs, wd_en, wd_clr;
  logic [12:0]        per_a, per_b;
  logic [5:0]         bdiv;
  int                 failures, tests_run, c;

  msc_top #(.PORT_W(8), .WATCHDOG_ENABLE_BIT_OPT(1'b0)) u_dut (
    .CLK(clk), .NRST(nrst), .POR_EVENT(por_ev), .EXT_RESET(ext_rst),
    .WATCHDOG_ENABLE_BIT_RESET(wd_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CPU_IMASK(imask), .STOP_ENTRY(stop), .IRQ_N(irq_n),
    .PORTB_IN(pb_in), .PORTB_DDR(pb_ddr), .WIRED_OR_INT_ENABLE(wor_en),
    .EXT_IRQ_REQ(ext_req), .IRQ_OUT(irq_out), .PULSE_A_PERIOD(per_a),
    .PULSE_B_PERIOD(per_b), .BUS_DIVIDE(bdiv), .SLOW_BUS_SELECT(sbs),
    .WATCHDOG_ENABLE(wd_en), .WATCHDOG_CLEAR(wd_clr));

  // ==========================================================
  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // Access and check tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(16'(rdata & m), 16'(exp), "register read");
  endtask

  // Counts high cycles of the request or the watchdog clear pulse,
  // starting with the cycle launched by the edge just passed
  task automatic cnt(input bit which, input int n);
    c = 0;
    repeat (n) begin
      #1;
      if ((which ? wd_clr : ext_req) === 1'b1) c++;
      @(posedge clk);
    end
  endtask

  // Derived outputs settle two cycles after a write
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Puts an interrupt source at its active or idle level
  task automatic drive(input bit src, input bit act);
    @(posedge clk);
    if (src) pb_in <= {7'h00, act};
    else irq_n <= ~act;
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Watchdog against a hung run
  initial begin
    #(3000 * 100);
    failures++;
    $display("MISMATCH at %0t: run did not complete", $time);
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {nrst, por_ev, ext_rst, wd_rst, wr, rd, imask, stop, wor_en} = '0;
    {addr, wdata, pb_in, pb_ddr} = '0;
    irq_n = 1'b1;
    failures = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(8'h0c, 8'hff, 8'h10);
    chk(16'(per_a), 16'h0100, "fast period");
    chk(16'(bdiv), 16'h0002, "bus divide");
    @(posedge clk) por_ev <= 1'b1;
    @(posedge clk) por_ev <= 1'b0;
    settle();
    rd_chk(8'h0c, 8'hff, 8'h90);
    // Protected bits refused while the CPU mask is clear
    wr_reg(8'h0c, 8'hff);
    cnt(1'b1, 3);
    chk(16'(c), 16'h0001, "watchdog clear pulse");
    rd_chk(8'h0c, 8'hff, 8'h9f);
    chk(16'(per_a), 16'h1000, "slow period a");
    chk(16'(per_b), 16'h1000, "slow period b");
    chk(16'({sbs, bdiv}), 16'h0060, "slow bus");
    chk(16'(wd_en), 16'h0001, "watchdog on");
    wr_reg(8'h0c, 8'h00);
    settle();
    rd_chk(8'h0c, 8'hff, 8'h11);
    chk(16'({per_b, bdiv}), 16'h4002, "fast again");
    @(posedge clk) imask <= 1'b1;
    wr_reg(8'h0c, 8'h62);
    rd_chk(8'h0c, 8'hff, 8'h63);
    @(posedge clk) stop <= 1'b1;
    @(posedge clk) stop <= 1'b0;
    settle();
    rd_chk(8'h0c, 8'hff, 8'h61);
    @(posedge clk) ext_rst <= 1'b1;
    @(posedge clk) ext_rst <= 1'b0;
    settle();
    rd_chk(8'h0c, 8'hff, 8'h10);
    wr_reg(8'h0c, 8'h11);
    @(posedge clk) wd_rst <= 1'b1;
    @(posedge clk) wd_rst <= 1'b0;
    settle();
    rd_chk(8'h0c, 8'hff, 8'h10);
    // Every sensitivity code on the pin and on the wired-OR port
    for (int src = 0; src < 2; src++) begin
      for (int s = 0; s < 4; s++) begin
        @(posedge clk) wor_en <= src[0];
        wr_reg(8'h0c, {1'b0, s[1:0], 5'h10});
        repeat (4) @(posedge clk);
        drive(src[0], 1'b1);
        cnt(1'b0, 4);
        chk(16'(c > 0), 16'(s != 2), "leading edge");
        cnt(1'b0, 4);
        chk(16'(c == 4), 16'(s == 0), "level");
        drive(src[0], 1'b0);
        cnt(1'b0, 4);
        if (s != 0) chk(16'(c > 0), 16'(s[1]), "trail edge");
        repeat (4) @(posedge clk);
      end
    end
    // Output pins and a disabled pin raise nothing
    @(posedge clk) pb_ddr <= 8'h01;
    drive(1'b1, 1'b1);
    cnt(1'b0, 4);
    chk(16'(c), 16'h0000, "output pin ignored");
    drive(1'b1, 1'b0);
    wr_reg(8'h0c, 8'h20);
    drive(1'b0, 1'b1);
    cnt(1'b0, 4);
    chk(16'(c), 16'h0000, "enable off");
    drive(1'b0, 1'b0);
    // Sticky status, mask and level output
    rd_chk(8'h10, 8'h03, 8'h03);
    wr_reg(8'h11, 8'h01);
    settle();
    chk(16'(irq_out), 16'h0001, "irq raised");
    wr_reg(8'h10, 8'h03);
    settle();
    chk(16'(irq_out), 16'h0000, "irq cleared");
    rd_chk(8'h10, 8'h03, 8'h00);
    rd_chk(8'h20, 8'hff, 8'h00);
    finish_test();
  end
endmodule
